// [verilog/usfc_cfg.svh]
// offsets, field positions, reset values and counts of the frame mode block
`ifndef USFC_CFG_SVH
`define USFC_CFG_SVH
`define USFC_OFF_CTRL 8'h00
`define USFC_OFF_MODE 8'h04
`define USFC_OFF_STAT 8'h14
`define USFC_OFF_LOCK 8'he4
`define USFC_MODE_RST 32'h0000_0000
`define USFC_F_MODE 0
`define USFC_F_BSRC 4
`define USFC_F_CLEN 6
`define USFC_F_SYNC 8
`define USFC_F_PAR 9
`define USFC_F_STOP 12
`define USFC_F_LOOP 14
`define USFC_F_BIT_ORDER_SEL 16
`define USFC_F_NINE 17
`define USFC_F_SERIAL_CLK_DRIVE 18
`define USFC_F_OVER 19
`define USFC_F_INAK 20
`define USFC_F_DNAK 21
`define USFC_F_VSYN 22
`define USFC_F_INV 23
`define USFC_F_MAXI 24
`define USFC_F_FILT 28
`define USFC_F_MAN 29
`define USFC_F_MSYN 30
`define USFC_F_ONEB 31
`define USFC_F_CPHA 8
`define USFC_F_CPOL 16
`define USFC_F_WRDB 20
`define USFC_F_CLRIT 13
`define USFC_DIV 8
`endif

// [verilog/usfc_pkg.sv]
// types shared by the frame mode block
package usfc_pkg;
  typedef enum logic [3:0] {
    USFC_NORMAL = 4'h0,
    USFC_RS485 = 4'h1,
    USFC_HANDSHAKE = 4'h2,
    USFC_CARD_T0 = 4'h4,
    USFC_CARD_T1 = 4'h6,
    USFC_IRDA = 4'h8,
    USFC_SPI_MASTER = 4'he,
    USFC_SPI_SLAVE = 4'hf
  } usfc_proto_t;
  typedef enum logic [2:0] {
    USFC_PAR_EVEN = 3'h0,
    USFC_PAR_ODD = 3'h1,
    USFC_PAR_SPACE = 3'h2,
    USFC_PAR_MARK = 3'h3,
    USFC_PAR_NONE = 3'h4,
    USFC_PAR_MDROP = 3'h6
  } usfc_par_t;
endpackage

// [verilog/usfc_frame_mode.sv]
// mode register, decode and line-side helpers of the serial port
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "usfc_cfg.svh"
// What this block does
// R01: decode protocol selector, 0x3 reserved
// R02: baud source clock, divide by eight, pin
// R03: length selector gives five to eight bits
// R04: nine bit option overrides length selector
// R05: clocked framing bit selects synchronous operation
// R06: parity type even odd space mark none multidrop
// R07: stop bits one, one-and-half, two
// R08: loop echo selector routes line paths
// R09: bit order lsb or msb first
// R10: drive clock pin unless external source
// R11: sample rate sixteen or eight times
// R12: inhibit option suppresses card non-acknowledge
// R13: repeat limit counting of parity errors
// R14: repeat limit holds zero to seven
// R15: software zeroes limit when counting off
// R16: data inversion on transmit and receive
// R17: variable delimiter updates sync per character
// R18: two of three receive line filter
// R19: manchester enable and start polarity
// R20: single bit or sync pattern delimiter
// R21: mode writes ignored while locked
// R22: spi layout uses alternate fields
// R23: spi phase sets change and capture edges
// R24: spi clock idle level from polarity
// R25: spi start waits for receive read
module usfc_frame_mode import usfc_pkg::*; #(
  parameter int DATA_W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic tx_ser_i,
  output logic rx_line_o,
  input wire logic sample_tick_i,
  output logic baud_tick_o,
  input wire logic [8:0] tx_data_i,
  input wire logic tx_sync_i,
  input wire logic tx_char_wr_i,
  output logic [8:0] tx_shift_o,
  input wire logic [8:0] rx_shift_i,
  output logic [8:0] rx_data_o,
  input wire logic parity_err_i,
  input wire logic char_ok_i,
  output logic nak_o,
  output logic repeat_limit_hit_o,
  input wire logic tx_ready_i,
  input wire logic rx_ready_flag_i,
  input wire logic spi_active_i,
  output logic spi_start_o,
  output usfc_proto_t proto_o,
  output logic [3:0] char_bits_o,
  output logic sync_mode_o,
  output usfc_par_t check_bit_type_o,
  output logic [2:0] stop_halves_o,
  output logic [4:0] oversample_o,
  output logic line_code_en_o,
  output logic manchester_start_polarity_o,
  output logic single_bit_delimiter_o,
  output logic sync_cmd_o,
  output logic spi_phase_o,
  output logic spi_pol_o
);
  // the character path is nine bits wide, any other DATA_W refused at elaboration
  if (DATA_W != 9) begin : g_bad_width
    $error("usfc_frame_mode serves only DATA_W of 9");
  end

  logic [31:0] mode_cfg; // raw mode register
  logic write_lock_en; // write protection
  logic [2:0] repeat_cnt; // successive parity errors
  logic repeat_limit_hit; // sticky limit flag
  logic rxd_m, rxd_s; // receive pin synchroniser
  logic sck_m, sck_s, sck_d; // clock pin synchroniser
  logic [2:0] div_cnt; // divide by eight counter
  logic [2:0] filt_sh; // filter samples
  logic filt_out; // filtered line
  logic tx_pend; // spi character waiting
  logic sync_cmd; // current sync field
  logic spi_mode; // spi layout active
  logic card_mode; // smart card protocol
  logic [1:0] baud_source_sel;
  logic [1:0] char_length_sel;
  logic [1:0] stop_bit_count;
  logic [1:0] loop_echo_sel;
  logic bit_order_sel, nine_bit_char, serial_clk_drive, suppress_card_nak;
  logic limit_repeat_nak, data_polarity_flip, var_delim, rx_filter_en;
  logic wait_rx_read, clr_repeat_limit_hit;
  logic [2:0] max_repeat;
  logic rx_src; // receiver source before filter
  logic [3:0] nbits; // active character length
  logic [8:0] next_tx, next_rx;

  // field extraction
  // R22: spi alternate layout
  assign spi_mode = (mode_cfg[3:0] == 4'he) || (mode_cfg[3:0] == 4'hf);
  assign card_mode = (mode_cfg[3:0] == 4'h4) || (mode_cfg[3:0] == 4'h6);
  assign baud_source_sel = mode_cfg[`USFC_F_BSRC +: 2];
  assign char_length_sel = mode_cfg[`USFC_F_CLEN +: 2];
  assign stop_bit_count = mode_cfg[`USFC_F_STOP +: 2];
  assign loop_echo_sel = mode_cfg[`USFC_F_LOOP +: 2];
  assign bit_order_sel = !spi_mode && mode_cfg[`USFC_F_BIT_ORDER_SEL];
  assign nine_bit_char = !spi_mode && mode_cfg[`USFC_F_NINE];
  assign serial_clk_drive = mode_cfg[`USFC_F_SERIAL_CLK_DRIVE];
  assign suppress_card_nak = mode_cfg[`USFC_F_INAK];
  assign limit_repeat_nak = mode_cfg[`USFC_F_DNAK];
  assign var_delim = mode_cfg[`USFC_F_VSYN];
  assign data_polarity_flip = !spi_mode && mode_cfg[`USFC_F_INV];
  // R14: limit range zero to seven
  assign max_repeat = mode_cfg[`USFC_F_MAXI +: 3];
  assign rx_filter_en = !spi_mode && mode_cfg[`USFC_F_FILT];
  assign wait_rx_read = spi_mode && mode_cfg[`USFC_F_WRDB];
  assign clr_repeat_limit_hit = wr_i && (addr_i == `USFC_OFF_CTRL) && wdata_i[`USFC_F_CLRIT];

  // protocol decode, reserved codes fall back to normal
  // R01: protocol selector decode
  always_comb begin
    unique case (mode_cfg[3:0])
      4'h1: proto_o = USFC_RS485;
      4'h2: proto_o = USFC_HANDSHAKE;
      4'h4: proto_o = USFC_CARD_T0;
      4'h6: proto_o = USFC_CARD_T1;
      4'h8: proto_o = USFC_IRDA;
      4'he: proto_o = USFC_SPI_MASTER;
      4'hf: proto_o = USFC_SPI_SLAVE;
      default: proto_o = USFC_NORMAL;
    endcase
  end

  // character length
  // R03: length selector, R04: nine bit override
  always_comb begin
    if (spi_mode) begin
      nbits = 4'd8;
    end else if (nine_bit_char) begin
      nbits = 4'd9;
    end else begin
      nbits = 4'd5 + {2'b00, char_length_sel};
    end
  end
  assign char_bits_o = nbits;
  // R05: synchronous select
  assign sync_mode_o = !spi_mode && mode_cfg[`USFC_F_SYNC];
  // parity type, reserved values read as none
  // R06: parity type decode
  always_comb begin
    unique case (mode_cfg[`USFC_F_PAR +: 3])
      3'h0: check_bit_type_o = USFC_PAR_EVEN;
      3'h1: check_bit_type_o = USFC_PAR_ODD;
      3'h2: check_bit_type_o = USFC_PAR_SPACE;
      3'h3: check_bit_type_o = USFC_PAR_MARK;
      3'h6: check_bit_type_o = USFC_PAR_MDROP;
      default: check_bit_type_o = USFC_PAR_NONE;
    endcase
  end

  // stop length in half bits
  // R07: one-and-half only asynchronous
  always_comb begin
    if (stop_bit_count == 2'd2) begin
      stop_halves_o = 3'd4;
    end else if (stop_bit_count == 2'd1 && !sync_mode_o) begin
      stop_halves_o = 3'd3;
    end else begin
      stop_halves_o = 3'd2;
    end
  end

  // R11: oversampling ratio
  assign oversample_o = mode_cfg[`USFC_F_OVER] ? 5'd8 : 5'd16;
  // R19: manchester enable and polarity
  assign line_code_en_o = !spi_mode && mode_cfg[`USFC_F_MAN];
  assign manchester_start_polarity_o = mode_cfg[`USFC_F_MSYN];
  // R20: delimiter selector
  assign single_bit_delimiter_o = mode_cfg[`USFC_F_ONEB];
  assign sync_cmd_o = sync_cmd;
  // R22: spi phase and polarity fields, R23: phase to character engine
  assign spi_phase_o = spi_mode && mode_cfg[`USFC_F_CPHA];
  assign spi_pol_o = spi_mode && mode_cfg[`USFC_F_CPOL];

  // register writes
  // R21: write lock blocks mode writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_cfg <= `USFC_MODE_RST;
    end else if (wr_i && addr_i == `USFC_OFF_MODE && !write_lock_en) begin
      mode_cfg <= wdata_i;
    end
  end

  // lock bit itself always writable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_lock_en <= 1'b0;
    end else if (wr_i && addr_i == `USFC_OFF_LOCK) begin
      write_lock_en <= wdata_i[0];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `USFC_OFF_MODE: rdata_o <= mode_cfg;
        `USFC_OFF_LOCK: rdata_o <= {31'h0000_0000, write_lock_en};
        `USFC_OFF_STAT: rdata_o <= {25'h000_0000, repeat_cnt, 2'b00, rx_ready_flag_i, repeat_limit_hit};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
    end else begin
      rxd_m <= rxd_i;
      rxd_s <= rxd_m;
      sck_m <= sck_i;
      sck_s <= sck_m;
      sck_d <= sck_s;
    end
  end

  // divide by eight prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 3'd0;
    end else begin
      div_cnt <= div_cnt + 3'd1;
    end
  end

  // baud source selection, reserved source gives no ticks
  // R02: baud source select
  always_comb begin
    unique case (baud_source_sel)
      2'd0: baud_tick_o = 1'b1;
      2'd1: baud_tick_o = (div_cnt == 3'(`USFC_DIV - 1));
      2'd3: baud_tick_o = sck_s && !sck_d;
      default: baud_tick_o = 1'b0;
    endcase
  end

  // clock pin drive
  // R10: drive only from internal source
  assign sck_oe_o = serial_clk_drive && (baud_source_sel != 2'd3);
  // output clock toggles on ticks, parks at idle level in spi
  // R24: spi idle level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o <= 1'b0;
    end else if (spi_mode && !spi_active_i) begin
      sck_o <= spi_pol_o;
    end else if (baud_tick_o) begin
      sck_o <= !sck_o;
    end
  end

  // receiver source routing
  // R08: loop echo selector
  always_comb begin
    unique case (loop_echo_sel)
      2'd2: rx_src = tx_ser_i;
      2'd3: rx_src = 1'b1;
      default: rx_src = rxd_s;
    endcase
  end

  // transmit pin routing, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
    end else if (loop_echo_sel == 2'd1 || loop_echo_sel == 2'd3) begin
      txd_o <= rxd_s;
    end else if (loop_echo_sel == 2'd2) begin
      txd_o <= 1'b1;
    end else begin
      txd_o <= tx_ser_i;
    end
  end

  // three sample majority filter
  // R18: two of three filter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_sh <= 3'b111;
      filt_out <= 1'b1;
    end else if (sample_tick_i) begin
      filt_sh <= {filt_sh[1:0], rx_src};
      filt_out <= (filt_sh[0] & filt_sh[1]) | (filt_sh[0] & rx_src) | (filt_sh[1] & rx_src);
    end
  end
  assign rx_line_o = rx_filter_en ? filt_out : rx_src;

  // bit order and polarity of the data field
  // R09: bit order, R16: inversion
  always_comb begin
    next_tx = 9'h000;
    next_rx = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nbits)) begin
        next_tx[i] = bit_order_sel ? tx_data_i[int'(nbits) - 1 - i] : tx_data_i[i];
        next_rx[i] = bit_order_sel ? rx_shift_i[int'(nbits) - 1 - i] : rx_shift_i[i];
        next_tx[i] = next_tx[i] ^ data_polarity_flip;
        next_rx[i] = next_rx[i] ^ data_polarity_flip;
      end
    end
  end

  // registered data views
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_shift_o <= 9'h000;
      rx_data_o <= 9'h000;
    end else begin
      tx_shift_o <= next_tx;
      rx_data_o <= next_rx;
    end
  end

  // sync field source
  // R17: variable delimiter update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_cmd <= 1'b0;
    end else if (!var_delim) begin
      sync_cmd <= manchester_start_polarity_o;
    end else if (tx_char_wr_i) begin
      sync_cmd <= tx_sync_i;
    end
  end

  // card non-acknowledge and repeat counting
  // R12: inhibit, R13: repeat limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nak_o <= 1'b0;
      repeat_cnt <= 3'd0;
    end else begin
      nak_o <= 1'b0;
      if (clr_repeat_limit_hit || char_ok_i) begin
        repeat_cnt <= 3'd0;
      end
      if (card_mode && parity_err_i && !suppress_card_nak) begin
        if (!limit_repeat_nak) begin
          nak_o <= 1'b1;
        end else if (repeat_cnt < max_repeat) begin
          nak_o <= 1'b1;
          repeat_cnt <= repeat_cnt + 3'd1;
        end
      end
    end
  end

  // sticky limit flag, set beats clear
  // R13: limit reached flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      repeat_limit_hit <= 1'b0;
    end else if (card_mode && parity_err_i && !suppress_card_nak && limit_repeat_nak && repeat_cnt >= max_repeat) begin
      repeat_limit_hit <= 1'b1;
    end else if (clr_repeat_limit_hit) begin
      repeat_limit_hit <= 1'b0;
    end
  end
  assign repeat_limit_hit_o = repeat_limit_hit;

  // pending spi character
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pend <= 1'b0;
    end else if (tx_char_wr_i) begin
      tx_pend <= 1'b1;
    end else if (spi_start_o) begin
      tx_pend <= 1'b0;
    end
  end

  // R25: wait for receive read
  assign spi_start_o = spi_mode && tx_pend && tx_ready_i && (!wait_rx_read || !rx_ready_flag_i);
endmodule

// [verification/usfc_frame_mode_properties.sv]
// checker of the mode register decode and card handshake
`timescale 1ns/10ps
`include "usfc_cfg.svh"
module usfc_frame_mode_properties import usfc_pkg::*; (
  input logic clk_i,
  input logic rst_i,
  input logic [7:0] addr_i,
  input logic [31:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  input logic [31:0] rdata_o,
  input logic parity_err_i,
  input logic nak_o,
  input logic sck_oe_o,
  input logic rx_ready_flag_i,
  input logic spi_start_o,
  input usfc_proto_t proto_o,
  input logic [3:0] char_bits_o,
  input logic [2:0] stop_halves_o,
  input logic [4:0] oversample_o,
  input logic spi_pol_o
);
  logic [31:0] mode_q; // mirror of the mode register
  logic lock_q; // mirror of the write lock
  logic spi; // either spi selector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 32'h0;
      lock_q <= 1'b0;
    end else if (wr_i && addr_i == `USFC_OFF_MODE && !lock_q) begin
      mode_q <= wdata_i;
    end else if (wr_i && addr_i == `USFC_OFF_LOCK) begin
      lock_q <= wdata_i[0];
    end
  end
  assign spi = mode_q[3:1] == 3'h7;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_proto; mode_q[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'he, 4'hf} |-> proto_o == mode_q[3:0]; endproperty
  a_proto: assert property (p_proto) else $error("protocol decode wrong");
  property p_chr; !spi |-> char_bits_o == (mode_q[17] ? 4'h9 : 4'h5 + {2'h0, mode_q[7:6]}); endproperty
  a_chr: assert property (p_chr) else $error("character length wrong");
  property p_stop; !spi && mode_q[13:12] != 2'h3 |-> stop_halves_o == (mode_q[13] ? 3'h4 : (mode_q[12] && !mode_q[8]) ? 3'h3 : 3'h2); endproperty
  a_stop: assert property (p_stop) else $error("stop bit count wrong");
  property p_over; !spi |-> oversample_o == (mode_q[19] ? 5'h08 : 5'h10); endproperty
  a_over: assert property (p_over) else $error("oversampling wrong");
  property p_serial_clk_drive; sck_oe_o == (mode_q[18] && mode_q[5:4] != 2'h3); endproperty
  a_serial_clk_drive: assert property (p_serial_clk_drive) else $error("clock drive enable wrong");
  property p_nak_on; parity_err_i && mode_q[3:0] == 4'h4 && mode_q[21:20] == 2'h0 |=>
    nak_o ##1 (!nak_o || $past(parity_err_i)); endproperty
  a_nak_on: assert property (p_nak_on) else $error("nak pulse missing");
  property p_nak_off; parity_err_i && mode_q[20] |=> !nak_o; endproperty
  a_nak_off: assert property (p_nak_off) else $error("nak not suppressed");
  property p_spi; spi |-> char_bits_o == 4'h8 && spi_pol_o == mode_q[16]; endproperty
  a_spi: assert property (p_spi) else $error("spi layout wrong");
  property p_start; spi && mode_q[20] && rx_ready_flag_i |-> !spi_start_o; endproperty
  a_start: assert property (p_start) else $error("spi start ignored read wait");
  property p_read; rd_i && addr_i == `USFC_OFF_MODE |=> rdata_o == $past(mode_q); endproperty
  a_read: assert property (p_read) else $error("mode readback wrong");
endmodule
bind usfc_frame_mode usfc_frame_mode_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .parity_err_i(parity_err_i), .nak_o(nak_o),
  .sck_oe_o(sck_oe_o), .rx_ready_flag_i(rx_ready_flag_i), .spi_start_o(spi_start_o), .proto_o(proto_o),
  .char_bits_o(char_bits_o), .stop_halves_o(stop_halves_o), .oversample_o(oversample_o), .spi_pol_o(spi_pol_o));

// [verification/usfc_line_peer.sv]
// serial line peer driving the receive pin and serial clock
`timescale 1ns/10ps
module usfc_line_peer (
  input wire logic clk_i,
  input wire logic level_i,
  input wire logic frame_i,
  output logic rxd_o,
  output logic sck_o
);
  initial rxd_o = 1'b1;
  initial sck_o = 1'b0;
  // line follows the commanded level
  always @(posedge clk_i) begin
    rxd_o <= level_i;
  end
  always @(posedge clk_i) begin
    if (frame_i) begin
      sck_o <= !sck_o;
    end
  end
endmodule

// [verification/testbench.sv]
// self-checking bench for the frame mode block
`timescale 1ns/10ps
`include "usfc_cfg.svh"
module testbench import usfc_pkg::*; ;
  logic clk, rst, wr_s, rd_s, perr, txrdy, rx_ready_flag, lvl, frame, tx_ser, tick, zero, chw, tsync;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [8:0] txd9, rxs, txsh, rxd9;
  logic rxd, txd, sck, sck_o, sck_oe, rxl, nak, hit, start, sync_m, phase, pol, lce, msp, sbd, btick, scmd;
  usfc_proto_t proto;
  usfc_par_t par;
  logic [3:0] cbits;
  logic [2:0] stop;
  logic [4:0] over;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  usfc_frame_mode uut (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .rxd_i(rxd), .txd_o(txd), .sck_i(sck), .sck_o(sck_o), .sck_oe_o(sck_oe), .tx_ser_i(tx_ser),
    .rx_line_o(rxl), .sample_tick_i(tick), .baud_tick_o(btick), .tx_data_i(txd9), .tx_sync_i(tsync),
    .tx_char_wr_i(chw),
    .tx_shift_o(txsh), .rx_shift_i(rxs), .rx_data_o(rxd9), .parity_err_i(perr), .char_ok_i(zero), .nak_o(nak),
    .repeat_limit_hit_o(hit), .tx_ready_i(txrdy), .rx_ready_flag_i(rx_ready_flag), .spi_active_i(zero),
    .spi_start_o(start), .proto_o(proto), .char_bits_o(cbits), .sync_mode_o(sync_m), .check_bit_type_o(par),
    .stop_halves_o(stop), .oversample_o(over), .line_code_en_o(lce), .manchester_start_polarity_o(msp),
    .single_bit_delimiter_o(sbd), .sync_cmd_o(scmd), .spi_phase_o(phase), .spi_pol_o(pol));
  usfc_line_peer peer (.clk_i(clk), .level_i(lvl), .frame_i(frame), .rxd_o(rxd), .sck_o(sck));
  // free running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      $display("MISMATCH %0t timeout", $time);
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h want %h", $time, m, got, exp);
      fails++;
    end
  endtask
  // one write cycle, ends settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wdata, wr_s} <= {a, d, 1'b1};
    @(posedge clk) wr_s <= 1'b0;
    @(negedge clk);
  endtask
  // one read cycle, data judged in the next cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) {addr, rd_s} <= {a, 1'b1};
    @(posedge clk) rd_s <= 1'b0;
    @(negedge clk) cmp(rdata, exp, "read data");
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_decode();
    logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'he, 4'hf, 4'h3};
    logic [2:0] pars[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    foreach (codes[i]) begin
      wr(`USFC_OFF_MODE, {28'h0, codes[i]});
      cmp(proto, (codes[i] == 4'h3) ? 4'h0 : codes[i], "protocol");
    end
    foreach (pars[i]) begin
      wr(`USFC_OFF_MODE, {20'h0, pars[i], 9'h0});
      cmp(par, pars[i], "parity type");
    end
    for (int i = 0; i < 4; i++) begin
      wr(`USFC_OFF_MODE, 32'(i) << 6);
      cmp(cbits, 5 + i, "length");
    end
    wr(`USFC_OFF_MODE, 32'h0002_10c0);
    cmp(cbits, 9, "nine bits");
    cmp(stop, 3, "one and half stop");
    wr(`USFC_OFF_MODE, 32'h0008_1100);
    cmp({sync_m, stop}, 4'ha, "sync stop");
    cmp(over, 8, "oversampling");
    wr(`USFC_OFF_MODE, 32'he000_0000);
    cmp({lce, msp, sbd}, 3'h7, "line code");
  endtask
  task automatic t_lock();
    wr(`USFC_OFF_MODE, 32'h0000_0a00);
    wr(`USFC_OFF_LOCK, 32'h1);
    wr(`USFC_OFF_MODE, 32'h0000_0040);
    rd(`USFC_OFF_MODE, 32'h0000_0a00);
    rd(8'h30, 32'h0);
    wr(`USFC_OFF_LOCK, 32'h0);
    wr(`USFC_OFF_MODE, 32'h0000_0040);
    rd(`USFC_OFF_MODE, 32'h0000_0040);
  endtask
  task automatic err(input logic en, input logic ef);
    @(posedge clk) perr <= 1'b1;
    @(posedge clk) perr <= 1'b0;
    @(negedge clk) cmp(nak, en, "nak");
    cmp(hit, ef, "limit flag");
  endtask
  task automatic t_card();
    wr(`USFC_OFF_MODE, 32'h4); // limit zero while counting off
    err(1, 0);
    wr(`USFC_OFF_MODE, 32'h0010_0004);
    err(0, 0);
    wr(`USFC_OFF_CTRL, 32'h2000);
    wr(`USFC_OFF_MODE, 32'h0120_0004);
    err(1, 0);
    err(0, 1);
    wr(`USFC_OFF_CTRL, 32'h2000);
    cmp(hit, 0, "flag cleared");
  endtask
  task automatic t_data();
    wr(`USFC_OFF_MODE, 32'h0080_00c0);
    @(posedge clk) txd9 <= 9'h0a5;
    idle(2);
    cmp(txsh, 9'h05a, "inverted tx");
    wr(`USFC_OFF_MODE, 32'h0080_0000);
    idle(1);
    cmp(txsh, 9'h01a, "inverted short tx");
    wr(`USFC_OFF_MODE, 32'h0082_0000);
    @(posedge clk) rxs <= 9'h0c3;
    idle(2);
    cmp(rxd9, 9'h13c, "inverted rx");
    wr(`USFC_OFF_MODE, 32'h0001_00c0);
    @(posedge clk) txd9 <= 9'h001;
    idle(2);
    cmp(txsh, 9'h080, "msb first");
  endtask
  task automatic t_loop();
    wr(`USFC_OFF_MODE, 32'h0000_c000);
    @(posedge clk) lvl <= 1'b0;
    idle(8);
    cmp({txd, rxl}, 2'b01, "remote loop");
    wr(`USFC_OFF_MODE, 32'h0000_8000);
    @(posedge clk) tx_ser <= 1'b0;
    idle(8);
    cmp({txd, rxl}, 2'b10, "local loop");
    wr(`USFC_OFF_MODE, 32'h0000_4000);
    idle(8);
    cmp(txd, 0, "echo");
    @(posedge clk) lvl <= 1'b1;
    wr(`USFC_OFF_MODE, 32'h0);
    idle(8);
    cmp({txd, rxl}, 2'b01, "normal path");
  endtask
  task automatic t_spi();
    wr(`USFC_OFF_MODE, 32'h0015_01ce);
    cmp({phase, pol, cbits}, 6'h38, "spi fields");
    cmp(sck_oe, 1, "spi clock driven");
    @(posedge clk) {txrdy, rx_ready_flag, frame, chw} <= 4'b1111;
    @(posedge clk) chw <= 1'b0;
    idle(3);
    cmp(start, 0, "start waits read");
    @(posedge clk) {rx_ready_flag, frame} <= 2'b00;
    @(negedge clk) cmp({start, sck_o}, 2'b11, "start and idle clock");
  endtask
  // counts baud enables over sixteen cycles
  task automatic ticks(input int exp, input string m);
    int n = 0;
    repeat (16) @(negedge clk) n += int'(btick);
    cmp(n, exp, m);
  endtask
  task automatic t_clk();
    wr(`USFC_OFF_MODE, 32'h0004_0000);
    cmp({btick, sck_oe}, 2'b11, "peripheral clock driven");
    wr(`USFC_OFF_MODE, 32'h0004_0010);
    ticks(2, "divide by eight");
    wr(`USFC_OFF_MODE, 32'h0004_0020);
    cmp(btick, 0, "reserved source");
    wr(`USFC_OFF_MODE, 32'h0004_0030);
    cmp(sck_oe, 0, "external clock undriven");
    @(posedge clk) frame <= 1'b1;
    idle(4);
    ticks(8, "external clock edges");
    @(posedge clk) frame <= 1'b0;
  endtask
  task automatic t_sync();
    wr(`USFC_OFF_MODE, 32'h4000_0000);
    idle(1);
    cmp(scmd, 1, "sync follows polarity");
    wr(`USFC_OFF_MODE, 32'h0040_0000);
    idle(1);
    cmp(scmd, 1, "sync held");
    @(posedge clk) {chw, tsync} <= 2'b10;
    @(posedge clk) chw <= 1'b0;
    @(negedge clk) cmp(scmd, 0, "sync per character");
  endtask
  task automatic t_filter();
    int n = 0;
    wr(`USFC_OFF_MODE, 32'h1000_0000);
    @(posedge clk) lvl <= 1'b0;
    @(posedge clk) lvl <= 1'b1;
    repeat (8) @(negedge clk) n += int'(!rxl);
    cmp(n, 0, "glitch filtered");
    @(posedge clk) lvl <= 1'b0;
    idle(8);
    cmp(rxl, 0, "low passes filter");
  endtask
  // main sequence
  initial begin
    {rst, lvl, tick, wr_s, rd_s, perr, txrdy, rx_ready_flag, frame, tx_ser, zero, chw, tsync} = 13'h1c08;
    {addr, wdata, txd9, rxs} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`USFC_OFF_MODE, `USFC_MODE_RST);
    cmp(txd, 1, "idle line");
    t_decode();
    t_lock();
    t_card();
    t_data();
    t_loop();
    t_spi();
    t_clk();
    t_sync();
    t_filter();
    conclude();
  end
endmodule
